// ===== inc/dpd_pkg.sv
/*
  dpd_pkg: object indices, reset values, legal ranges, status bit
  positions and timing counts for the drive parameter dictionary.
  Assumes a single 250 MHz clock and 16-bit object indices.
*/
package dpd_pkg;

  // clock and time base
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_MS = 1;
  localparam int MS_CYCLES = TICK_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int AVG_STEP_MS = 5;
  localparam int AVG_STEP_TICKS = AVG_STEP_MS / TICK_MS;

  // object indices
  localparam logic [15:0] IDX_UPPER_END = 16'h2028;
  localparam logic [15:0] IDX_HOLD = 16'h202B;
  localparam logic [15:0] IDX_ROT = 16'h202C;
  localparam logic [15:0] IDX_APPR = 16'h202D;
  localparam logic [15:0] IDX_PAUSE = 16'h202E;
  localparam logic [15:0] IDX_SPEED = 16'h2030;
  localparam logic [15:0] IDX_PEAK = 16'h2031;
  localparam logic [15:0] IDX_TORQUE = 16'h2033;
  localparam logic [15:0] IDX_LOGIC_V = 16'h203A;
  localparam logic [15:0] IDX_DRIVE_V = 16'h203B;
  localparam logic [15:0] IDX_VTHR = 16'h203C;
  localparam logic [15:0] IDX_VAVG = 16'h203D;
  localparam logic [15:0] IDX_TLIM = 16'h203E;
  localparam logic [15:0] IDX_TEMP = 16'h203F;
  localparam logic [15:0] IDX_DATE = 16'h2040;
  localparam logic [15:0] IDX_SERIAL = 16'h2041;
  localparam logic [15:0] IDX_END_HOLD = 16'h2042;

  // reset values
  localparam logic [31:0] RST_UPPER_END = 32'h0001_9000;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  localparam logic [15:0] RST_ROT = 16'h0000;
  localparam logic [15:0] RST_APPR = 16'h0000;
  localparam logic [15:0] RST_PAUSE = 16'h000A;
  localparam logic [15:0] RST_VTHR = 16'h00B9;
  localparam logic [15:0] RST_VAVG = 16'h0064;
  localparam logic [15:0] RST_TLIM = 16'h0046;
  localparam logic [15:0] RST_END_HOLD = 16'h0000;

  // legal write ranges
  localparam logic [15:0] BIN_MAX = 16'h0001;
  localparam logic [15:0] PAUSE_MIN = 16'h000A;
  localparam logic [15:0] PAUSE_MAX = 16'h2710;
  localparam logic [15:0] VTHR_MIN = 16'h00B4;
  localparam logic [15:0] VTHR_MAX = 16'h00F0;
  localparam logic [15:0] VAVG_MIN = 16'h0064;
  localparam logic [15:0] VAVG_MAX = 16'h03E8;
  localparam logic [15:0] TLIM_MIN = 16'h000A;
  localparam logic [15:0] TLIM_MAX = 16'h0046;
  localparam logic [17:0] MAP_SPAN = 18'h3_2000;

  // drive status word bit positions
  localparam int STAT_POWER_BIT = 4;
  localparam int STAT_TEMP_BIT = 7;

endpackage : dpd_pkg

// ===== rtl/dpd_tick_div.sv
/*
  dpd_tick_div: counts enabled cycles and emits a one-cycle tick every
  COUNT of them. Assumes clear and enable come from the same clock.
*/
module dpd_tick_div
#(
  parameter int COUNT = 4
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic clear,
  input wire logic enable,
  output logic tick
);

  localparam int W = $clog2(COUNT) + 1;
  localparam logic [W-1:0] LAST = W'(COUNT - 1);

  logic [W-1:0] cnt;

  // clear restarts the period so a new interval is always whole
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cnt <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (clear)
        cnt <= '0;
      else if (enable)
      begin
        tick <= (cnt == LAST);
        cnt <= (cnt == LAST) ? '0 : cnt + W'(1);
      end
    end
  end

endmodule : dpd_tick_div

// ===== rtl/dpd_volt_avg.sv
/*
  dpd_volt_avg: sums one voltage sample per step tick over a window of
  steps, then divides by the window with a serial restoring divider.
  Assumes window >= 1 and ticks far apart compared with 27 cycles.
*/
module dpd_volt_avg
  import dpd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic stepTick,
  input wire logic [15:0] sample,
  input wire logic [15:0] window,
  output logic [15:0] avg
);

  typedef enum logic [1:0] {AVG_ACCUM, AVG_DIVIDE, AVG_LOAD} dpd_avg_state_t;

  dpd_avg_state_t state;
  logic [25:0] sum;
  logic [25:0] quo;
  logic [16:0] rem;
  logic [16:0] remShift;
  logic [4:0] bitsLeft;
  logic [15:0] cnt;
  logic [15:0] win;
  logic [15:0] limit;

  // window is latched at the first sample so a mid-window write waits
  assign limit = (cnt == 16'h0000) ? window : win;
  assign remShift = {rem[15:0], quo[25]};

  // accumulate, divide, load
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= AVG_ACCUM;
      sum <= 26'h0;
      quo <= 26'h0;
      rem <= 17'h0;
      bitsLeft <= 5'h0;
      cnt <= 16'h0000;
      win <= RST_VAVG;
      avg <= 16'h0000;
    end
    else
      case (state)
        AVG_ACCUM:
          if (stepTick)
          begin
            win <= limit;
            if (cnt + 16'h0001 >= limit)
            begin
              quo <= sum + 26'(sample);
              rem <= 17'h0;
              bitsLeft <= 5'h19;
              sum <= 26'h0;
              cnt <= 16'h0000;
              state <= AVG_DIVIDE;
            end
            else
            begin
              sum <= sum + 26'(sample);
              cnt <= cnt + 16'h0001;
            end
          end
        AVG_DIVIDE:
        begin
          rem <= (remShift >= {1'b0, win}) ? remShift - {1'b0, win} : remShift;
          quo <= {quo[24:0], remShift >= {1'b0, win}};
          bitsLeft <= bitsLeft - 5'h1;
          if (bitsLeft == 5'h0)
            state <= AVG_LOAD;
        end
        AVG_LOAD:
        begin
          avg <= quo[15:0];
          state <= AVG_ACCUM;
        end
        default:
          state <= AVG_ACCUM;
      endcase
  end

  a_avg_count:
  assert property (@(posedge clk) disable iff (!resetn)
    state == AVG_ACCUM && cnt != 16'h0000 |-> cnt < win)
  else $error("averaging window overran its length");

endmodule : dpd_volt_avg

// ===== rtl/dpd_param_dict.sv
/*
  dpd_param_dict: a slice of the drive's object dictionary with its
  settings, measurement readouts and the two status bits they drive.
  Assumes the object access engine and the measurement logic sit on
  the same clock; one request per cycle at most, answered next cycle.
*/
// How it works
// - rotation sense: 0 clockwise, 1 counter clockwise
// - approach finishes with forward or reverse loop
// - pause idle milliseconds on each reversal that arrives while no pause is running
// - peak torque of run, skip start, braking
// - supply voltage readouts read-only, tenth volts
// - power present: averaged voltage against threshold
// - voltage averaged over window of 5 ms steps
// - programmable temperature limit, default seventy
// - internal temperature readout, whole degrees
// - signed upper range end with bounds
// - manufacture date readout as year week
// - standstill holding torque clamped to maximum
// - power present shows as status bit 4
// - over temperature shows as status bit 7
module dpd_param_dict
  import dpd_pkg::*;
#(
  parameter int MS_CNT = MS_CYCLES
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sdoReq,
  input wire logic sdoWrite,
  input wire logic [15:0] sdoIndex,
  input wire logic [31:0] sdoWdata,
  output logic sdoDone,
  output logic sdoAbort,
  output logic [31:0] sdoRdata,
  input wire logic [15:0] speedNow,
  input wire logic [15:0] torqueNow,
  input wire logic [15:0] logicVoltNow,
  input wire logic [15:0] driveVoltNow,
  input wire logic [15:0] tempNow,
  input wire logic [15:0] yearWeekCode,
  input wire logic [15:0] unitSerialIn,
  input wire logic runActive,
  input wire logic startPhase,
  input wire logic brakePhase,
  input wire logic reverseEvent,
  input wire logic standstill,
  input wire logic [15:0] holdDemand,
  input wire logic [31:0] refValue,
  input wire logic [15:0] scaleNum,
  input wire logic [15:0] scaleDen,
  output logic rotationCcw,
  output logic approachReverse,
  output logic reversePauseBusy,
  output logic [31:0] rangeUpper,
  output logic [15:0] holdTorqueCmd,
  output logic [15:0] endRunHoldTorque,
  output logic [15:0] driveStatusBits
);

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  // settings
  logic [31:0] upperRangeEnd;
  logic [15:0] standstillHoldingTorque;
  logic [15:0] rotationSense;
  logic [15:0] approachDirection;
  logic [15:0] reversalPause;
  logic [15:0] driveVoltageThreshold;
  logic [15:0] driveVoltageAverageTime;
  logic [15:0] overheatLimit;
  logic [15:0] endOfRunHoldingTorque;
  // readouts
  logic [15:0] speedReadout;
  logic [15:0] peakRunTorque;
  logic [15:0] torqueReadout;
  logic [15:0] logicSupplyVoltage;
  logic [15:0] driveSupplyVoltage;
  logic [15:0] internalTemperature;
  logic [15:0] manufactureYearWeek;
  logic [15:0] unitSerial;
  // access decode
  logic [15:0] wr16;
  logic [31:0] next_rdata;
  logic next_abort;
  logic known;
  logic readOnly;
  logic inRange;
  logic wrAcc;
  // range end bound check
  logic signed [33:0] mapOff;
  logic signed [50:0] mapProd;
  logic [33:0] spanDen;
  logic mapOk;
  // timing and averaging
  logic pauseStart;
  logic pauseTick;
  logic [15:0] pauseLeft;
  logic avgMsTick;
  logic avgStepTick;
  logic [15:0] avgVolt;
  logic runSeen;
  logic peakWindow;

  assign wr16 = sdoWdata[15:0];

  // value lies in [ref+1, span*den/num - 1 + ref]; multiply, never divide
  assign mapOff = 34'(signed'(sdoWdata)) - 34'(signed'(refValue)) + 34'sd1;
  assign spanDen = 34'(MAP_SPAN) * 34'(scaleDen);
  assign mapProd = 51'(mapOff) * 51'($signed({1'b0, scaleNum}));
  assign mapOk = (scaleNum != 16'h0000) && (mapOff >= 34'sd2)
    && (mapProd <= $signed({17'h0, spanDen}));

  // object decode: read value, access class and legal range
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    known = 1'b1;
    readOnly = 1'b0;
    inRange = 1'b1;
    case (sdoIndex)
      IDX_UPPER_END:
      begin
        next_rdata = upperRangeEnd;
        inRange = mapOk;
      end
      IDX_HOLD: next_rdata = {16'h0000, standstillHoldingTorque};
      IDX_ROT:
      begin
        next_rdata = {16'h0000, rotationSense};
        inRange = wr16 <= BIN_MAX;
      end
      IDX_APPR:
      begin
        next_rdata = {16'h0000, approachDirection};
        inRange = wr16 <= BIN_MAX;
      end
      IDX_PAUSE:
      begin
        next_rdata = {16'h0000, reversalPause};
        inRange = wr16 >= PAUSE_MIN && wr16 <= PAUSE_MAX;
      end
      IDX_VTHR:
      begin
        next_rdata = {16'h0000, driveVoltageThreshold};
        inRange = wr16 >= VTHR_MIN && wr16 <= VTHR_MAX;
      end
      IDX_VAVG:
      begin
        next_rdata = {16'h0000, driveVoltageAverageTime};
        inRange = wr16 >= VAVG_MIN && wr16 <= VAVG_MAX;
      end
      IDX_TLIM:
      begin
        next_rdata = {16'h0000, overheatLimit};
        inRange = wr16 >= TLIM_MIN && wr16 <= TLIM_MAX;
      end
      IDX_END_HOLD: next_rdata = {16'h0000, endOfRunHoldingTorque};
      IDX_SPEED:
      begin
        next_rdata = {16'h0000, speedReadout};
        readOnly = 1'b1;
      end
      IDX_PEAK:
      begin
        next_rdata = {16'h0000, peakRunTorque};
        readOnly = 1'b1;
      end
      IDX_TORQUE:
      begin
        next_rdata = {16'h0000, torqueReadout};
        readOnly = 1'b1;
      end
      IDX_LOGIC_V:
      begin
        next_rdata = {16'h0000, logicSupplyVoltage};
        readOnly = 1'b1;
      end
      IDX_DRIVE_V:
      begin
        next_rdata = {16'h0000, driveSupplyVoltage};
        readOnly = 1'b1;
      end
      IDX_TEMP:
      begin
        next_rdata = {16'h0000, internalTemperature};
        readOnly = 1'b1;
      end
      IDX_DATE:
      begin
        next_rdata = {16'h0000, manufactureYearWeek};
        readOnly = 1'b1;
      end
      IDX_SERIAL:
      begin
        next_rdata = {16'h0000, unitSerial};
        readOnly = 1'b1;
      end
      default: known = 1'b0;
    endcase
    // unknown objects abort both ways; bad writes abort and store nothing
    next_abort = !known || (sdoWrite && (readOnly || !inRange));
  end

  assign wrAcc = sdoReq && sdoWrite && !next_abort;

  // answer one cycle after each request
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sdoDone <= 1'b0;
      sdoAbort <= 1'b0;
      sdoRdata <= 32'h0000_0000;
    end
    else
    begin
      sdoDone <= sdoReq;
      sdoAbort <= sdoReq && next_abort;
      if (sdoReq)
        sdoRdata <= (sdoWrite || next_abort) ? 32'h0000_0000 : next_rdata;
    end
  end

  // writable settings, only touched by an accepted write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      upperRangeEnd <= RST_UPPER_END;
      standstillHoldingTorque <= RST_HOLD;
      rotationSense <= RST_ROT;
      approachDirection <= RST_APPR;
      reversalPause <= RST_PAUSE;
      driveVoltageThreshold <= RST_VTHR;
      driveVoltageAverageTime <= RST_VAVG;
      overheatLimit <= RST_TLIM;
      endOfRunHoldingTorque <= RST_END_HOLD;
    end
    else if (wrAcc)
      case (sdoIndex)
        IDX_UPPER_END: upperRangeEnd <= sdoWdata;
        IDX_HOLD: standstillHoldingTorque <= wr16;
        IDX_ROT: rotationSense <= wr16;
        IDX_APPR: approachDirection <= wr16;
        IDX_PAUSE: reversalPause <= wr16;
        IDX_VTHR: driveVoltageThreshold <= wr16;
        IDX_VAVG: driveVoltageAverageTime <= wr16;
        IDX_TLIM: overheatLimit <= wr16;
        IDX_END_HOLD: endOfRunHoldingTorque <= wr16;
        default: upperRangeEnd <= upperRangeEnd;
      endcase
  end

  // settings out to the motion logic, held in flip-flops
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rotationCcw <= 1'b0;
      approachReverse <= 1'b0;
      rangeUpper <= RST_UPPER_END;
      endRunHoldTorque <= RST_END_HOLD;
      holdTorqueCmd <= 16'h0000;
    end
    else
    begin
      rotationCcw <= rotationSense[0];
      approachReverse <= approachDirection[0];
      rangeUpper <= upperRangeEnd;
      endRunHoldTorque <= endOfRunHoldingTorque;
      // clamp only at standstill; running torque is limited elsewhere
      if (standstill && holdDemand > standstillHoldingTorque)
        holdTorqueCmd <= standstillHoldingTorque;
      else
        holdTorqueCmd <= holdDemand;
    end
  end

  // measurement capture, one cycle behind the sources
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      speedReadout <= 16'h0000;
      torqueReadout <= 16'h0000;
      logicSupplyVoltage <= 16'h0000;
      driveSupplyVoltage <= 16'h0000;
      internalTemperature <= 16'h0000;
      manufactureYearWeek <= 16'h0000;
      unitSerial <= 16'h0000;
    end
    else
    begin
      speedReadout <= speedNow;
      torqueReadout <= torqueNow;
      logicSupplyVoltage <= logicVoltNow;
      driveSupplyVoltage <= driveVoltNow;
      internalTemperature <= tempNow;
      manufactureYearWeek <= yearWeekCode;
      unitSerial <= unitSerialIn;
    end
  end

  // peak torque restarts with each run
  assign peakWindow = runActive && !startPhase && !brakePhase;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      runSeen <= 1'b0;
      peakRunTorque <= 16'h0000;
    end
    else
    begin
      runSeen <= runActive;
      if (runActive && !runSeen)
        peakRunTorque <= peakWindow ? torqueNow : 16'h0000;
      else if (peakWindow && torqueNow > peakRunTorque)
        peakRunTorque <= torqueNow;
    end
  end

  // reversal pause: millisecond divider restarts so the first ms is whole
  assign pauseStart = reverseEvent && !reversePauseBusy;

  dpd_tick_div #(.COUNT(MS_CNT)) pauseDiv (
    .clk(clk),
    .resetn(resetn),
    .clear(pauseStart),
    .enable(reversePauseBusy),
    .tick(pauseTick)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reversePauseBusy <= 1'b0;
      pauseLeft <= 16'h0000;
    end
    else if (pauseStart)
    begin
      reversePauseBusy <= 1'b1;
      pauseLeft <= reversalPause;
    end
    else if (reversePauseBusy && pauseTick)
    begin
      reversePauseBusy <= (pauseLeft != 16'h0001);
      pauseLeft <= pauseLeft - 16'h0001;
    end
  end

  // averaging time base: free-running ms, then 5 ms steps
  dpd_tick_div #(.COUNT(MS_CNT)) avgMsDiv (
    .clk(clk),
    .resetn(resetn),
    .clear(1'b0),
    .enable(1'b1),
    .tick(avgMsTick)
  );

  dpd_tick_div #(.COUNT(AVG_STEP_TICKS)) avgStepDiv (
    .clk(clk),
    .resetn(resetn),
    .clear(1'b0),
    .enable(avgMsTick),
    .tick(avgStepTick)
  );

  dpd_volt_avg voltAvg (
    .clk(clk),
    .resetn(resetn),
    .stepTick(avgStepTick),
    .sample(driveSupplyVoltage),
    .window(driveVoltageAverageTime),
    .avg(avgVolt)
  );

  // status bits; power reads absent until the first window completes
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      driveStatusBits <= 16'h0000;
    else
    begin
      driveStatusBits[STAT_POWER_BIT] <= avgVolt >= driveVoltageThreshold;
      driveStatusBits[STAT_TEMP_BIT] <= internalTemperature > overheatLimit;
    end
  end

  a_rot_write:
  assert property (wrAcc && sdoIndex == IDX_ROT |=> ##1 rotationCcw == $past(wr16[0], 2))
  else $error("rotation sense output missed a write");

  a_appr_write:
  assert property (wrAcc && sdoIndex == IDX_APPR |=> ##1 approachReverse == $past(wr16[0], 2))
  else $error("approach direction output missed a write");

  a_pause_load:
  assert property (reverseEvent && !reversePauseBusy
    |=> reversePauseBusy && pauseLeft == $past(reversalPause))
  else $error("reversal pause not loaded");

  a_peak_hold:
  assert property (peakWindow |=> peakRunTorque >= $past(torqueNow))
  else $error("peak torque below a counted sample");

  a_volt_read:
  assert property (sdoReq && !sdoWrite && sdoIndex == IDX_DRIVE_V
    |=> sdoDone && !sdoAbort && sdoRdata == {16'h0000, $past(driveSupplyVoltage)})
  else $error("drive voltage readout wrong");

  a_power_bit:
  assert property (driveStatusBits[STAT_POWER_BIT] == $past(avgVolt >= driveVoltageThreshold))
  else $error("power present bit disagrees with threshold");

  a_temp_bit:
  assert property (##1 driveStatusBits[STAT_TEMP_BIT]
    == $past(internalTemperature > overheatLimit))
  else $error("temperature bit disagrees with limit");

  a_range_abort:
  assert property (sdoReq && sdoWrite && sdoIndex == IDX_PAUSE && wr16 < PAUSE_MIN
    |=> sdoDone && sdoAbort && reversalPause == $past(reversalPause))
  else $error("out of range pause write not aborted");

  a_ro_abort:
  assert property (sdoReq && sdoWrite && sdoIndex == IDX_TEMP |=> sdoDone && sdoAbort)
  else $error("write to readout not aborted");

  a_map_low:
  assert property (sdoReq && sdoWrite && sdoIndex == IDX_UPPER_END
    && $signed(sdoWdata) <= $signed(refValue) |=> sdoAbort)
  else $error("range end at or below reference accepted");

  a_hold_clamp:
  assert property (standstill && holdDemand > standstillHoldingTorque
    |=> holdTorqueCmd == $past(standstillHoldingTorque))
  else $error("standstill holding torque not clamped");

endmodule : dpd_param_dict

// ===== tb/dpd_sdo_master.sv
/*
  dpd_sdo_master: behavioural object access master for the bench.
  Assumes one request per access, answered on the following cycle.
*/
module dpd_sdo_master
(
  input wire logic clk,
  output logic sdoReq,
  output logic sdoWrite,
  output logic [15:0] sdoIndex,
  output logic [31:0] sdoWdata,
  input wire logic sdoDone,
  input wire logic sdoAbort,
  input wire logic [31:0] sdoRdata
);
  timeunit 1ns;
  timeprecision 100ps;
  int idleGap = 0;

  // idle bus at time zero
  initial
  begin
    sdoReq = 1'b0;
    sdoWrite = 1'b0;
    sdoIndex = 16'h0000;
    sdoWdata = 32'h0000_0000;
  end

  // released index and data lines carry the inverse so stale values never pass
  task automatic xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
    output logic [31:0] rd, output logic ab);
    int n;
    n = 0;
    repeat (idleGap) @(posedge clk);
    @(posedge clk);
    sdoReq <= 1'b1;
    sdoWrite <= w;
    sdoIndex <= i;
    sdoWdata <= d;
    @(posedge clk);
    sdoReq <= 1'b0;
    sdoIndex <= ~i;
    sdoWdata <= ~d;
    #1;
    while (sdoDone !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    rd = sdoRdata;
    // a late or missing answer returns unknown so no expectation passes
    ab = (sdoDone === 1'b1 && n == 0) ? sdoAbort : 1'bx;
  endtask : xfer
endmodule : dpd_sdo_master

// ===== tb/dpd_param_dict_tb.sv
/*
  dpd_param_dict_tb: self-checking bench for the parameter dictionary.
  Assumes a 4 ns clock and a shortened millisecond of 4 cycles.
*/
module dpd_param_dict_tb
  import dpd_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MS = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sdoReq, sdoWrite, sdoDone, sdoAbort, ab;
  logic [15:0] sdoIndex;
  logic [31:0] sdoWdata, sdoRdata, rd;
  logic [15:0] speedNow = 16'h0BB8, torqueNow = 16'h0000, logicVoltNow = 16'h00F0;
  logic [15:0] driveVoltNow = 16'h00C8, tempNow = 16'h0046, yearWeekCode = 16'h1834;
  logic [15:0] unitSerialIn = 16'hBEEF, holdDemand = 16'h0050;
  logic runActive = 1'b0, startPhase = 1'b0, brakePhase = 1'b0;
  logic reverseEvent = 1'b0, standstill = 1'b0;
  logic [31:0] refValue = 32'h0000_0000;
  logic [15:0] scaleNum = 16'h0001, scaleDen = 16'h0001;
  logic rotationCcw, approachReverse, reversePauseBusy;
  logic [31:0] rangeUpper;
  logic [15:0] holdTorqueCmd, endRunHoldTorque, driveStatusBits;
  logic [31:0] sh[logic [15:0]];
  int nFail = 0;
  int compares = 0;
  int cyc = 0;

  // clock and a cycle count since reset release
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= resetn ? cyc + 1 : 0;

  dpd_param_dict #(.MS_CNT(MS)) u_dpd_param_dict (.clk(clk), .resetn(resetn),
    .sdoReq(sdoReq), .sdoWrite(sdoWrite), .sdoIndex(sdoIndex), .sdoWdata(sdoWdata),
    .sdoDone(sdoDone), .sdoAbort(sdoAbort), .sdoRdata(sdoRdata), .speedNow(speedNow),
    .torqueNow(torqueNow), .logicVoltNow(logicVoltNow), .driveVoltNow(driveVoltNow),
    .tempNow(tempNow), .yearWeekCode(yearWeekCode), .unitSerialIn(unitSerialIn),
    .runActive(runActive), .startPhase(startPhase), .brakePhase(brakePhase),
    .reverseEvent(reverseEvent), .standstill(standstill), .holdDemand(holdDemand),
    .refValue(refValue), .scaleNum(scaleNum), .scaleDen(scaleDen),
    .rotationCcw(rotationCcw), .approachReverse(approachReverse),
    .reversePauseBusy(reversePauseBusy), .rangeUpper(rangeUpper),
    .holdTorqueCmd(holdTorqueCmd), .endRunHoldTorque(endRunHoldTorque),
    .driveStatusBits(driveStatusBits));

  dpd_sdo_master u_dpd_sdo_master (.clk(clk), .sdoReq(sdoReq), .sdoWrite(sdoWrite),
    .sdoIndex(sdoIndex), .sdoWdata(sdoWdata), .sdoDone(sdoDone), .sdoAbort(sdoAbort),
    .sdoRdata(sdoRdata));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one access, judging refusal flag and returned data
  task automatic acc(input logic w, input logic [15:0] i, input logic [31:0] d,
    input logic eab, input logic [31:0] erd);
    u_dpd_sdo_master.xfer(w, i, d, rd, ab);
    chk({31'h0, ab}, {31'h0, eab});
    chk(rd, erd);
  endtask : acc

  task automatic t_defaults;
    logic [15:0] ix[9] = '{IDX_UPPER_END, IDX_HOLD, IDX_ROT, IDX_APPR, IDX_PAUSE,
      IDX_VTHR, IDX_VAVG, IDX_TLIM, IDX_END_HOLD};
    logic [31:0] v[9] = '{32'h0001_9000, 32'h0, 32'h0, 32'h0, 32'h0000_000A,
      32'h0000_00B9, 32'h0000_0064, 32'h0000_0046, 32'h0};
    for (int k = 0; k < 9; k++)
    begin
      sh[ix[k]] = v[k];
      acc(1'b0, ix[k], 32'h0, 1'b0, v[k]);
    end
    chk({31'h0, rotationCcw}, 32'h0);
    chk(rangeUpper, 32'h0001_9000);
    $display("test defaults done");
  endtask : t_defaults

  // boundary writes: bit 48 marks a write that must be refused
  task automatic t_ranges;
    logic [51:0] e;
    logic [51:0] tab[19] = '{52'h1_202C_0000_0002, 52'h0_202C_0000_0001,
      52'h1_202D_0000_0002, 52'h0_202D_0000_0001, 52'h1_202E_0000_0009,
      52'h1_202E_0000_2711, 52'h0_202E_0000_2710, 52'h1_203C_0000_00B3,
      52'h1_203C_0000_00F1, 52'h0_203C_0000_00F0, 52'h1_203D_0000_0063,
      52'h1_203D_0000_03E9, 52'h0_203D_0000_03E8, 52'h1_203E_0000_0009,
      52'h1_203E_0000_0047, 52'h0_203E_0000_000A, 52'h1_2028_0000_0000,
      52'h1_2028_0003_2000, 52'h0_2028_0003_1FFF};
    for (int k = 0; k < 19; k++)
    begin
      e = tab[k];
      if (!e[48])
        sh[e[47:32]] = e[31:0];
      acc(1'b1, e[47:32], e[31:0], e[48], 32'h0);
      acc(1'b0, e[47:32], 32'h0, 1'b0, sh[e[47:32]]);
    end
    acc(1'b0, 16'h2029, 32'h0, 1'b1, 32'h0);
    chk({30'h0, rotationCcw, approachReverse}, 32'h3);
    chk(rangeUpper, 32'h0003_1FFF);
    // shifted reference and halved span move both bounds
    @(posedge clk);
    refValue <= 32'h0000_0100;
    scaleNum <= 16'h0002;
    acc(1'b1, IDX_UPPER_END, 32'h0000_0100, 1'b1, 32'h0);
    acc(1'b1, IDX_UPPER_END, 32'h0001_9100, 1'b1, 32'h0);
    acc(1'b1, IDX_UPPER_END, 32'h0001_90FF, 1'b0, 32'h0);
    acc(1'b0, IDX_UPPER_END, 32'h0, 1'b0, 32'h0001_90FF);
    $display("test ranges done");
  endtask : t_ranges

  // live readouts, and writes to them must be refused
  task automatic t_readouts;
    logic [15:0] ix[7] = '{IDX_SPEED, IDX_TORQUE, IDX_LOGIC_V, IDX_DRIVE_V, IDX_TEMP,
      IDX_DATE, IDX_SERIAL};
    logic [15:0] v[7];
    v = '{speedNow, torqueNow, logicVoltNow, driveVoltNow, tempNow, yearWeekCode,
      unitSerialIn};
    for (int k = 0; k < 7; k++)
    begin
      acc(1'b1, ix[k], 32'h1234, 1'b1, 32'h0);
      acc(1'b0, ix[k], 32'h0, 1'b0, {16'h0, v[k]});
    end
    $display("test readouts done");
  endtask : t_readouts

  task automatic t_status;
    int n;
    n = 0;
    chk({31'h0, driveStatusBits[7]}, 32'h1);
    acc(1'b1, IDX_TLIM, 32'h46, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, driveStatusBits[7]}, 32'h0);
    tempNow <= 16'h0047;
    repeat (4) @(posedge clk);
    chk({31'h0, driveStatusBits[7]}, 32'h1);
    acc(1'b1, IDX_VAVG, 32'h64, 1'b0, 32'h0);
    acc(1'b1, IDX_VTHR, 32'hC8, 1'b0, 32'h0);
    chk({31'h0, driveStatusBits[4]}, 32'h0);
    while (driveStatusBits[4] !== 1'b1 && n < 4000)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({31'h0, cyc >= 100 * 5 * MS}, 32'h1);
    chk({16'h0, driveStatusBits & 16'hFF7F}, 32'h0010);
    acc(1'b1, IDX_VTHR, 32'hC9, 1'b0, 32'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, driveStatusBits[4]}, 32'h0);
    $display("test status done");
  endtask : t_status

  // a second reversal while busy must not restart the pause
  task automatic t_pause;
    int n;
    n = 0;
    acc(1'b1, IDX_PAUSE, 32'hB, 1'b0, 32'h0);
    @(posedge clk);
    reverseEvent <= 1'b1;
    @(posedge clk);
    reverseEvent <= 1'b0;
    #1;
    chk({31'h0, reversePauseBusy}, 32'h1);
    while (reversePauseBusy === 1'b1 && n < 200)
    begin
      @(posedge clk);
      reverseEvent <= (n == 20);
      #1;
      n++;
    end
    chk({31'h0, n >= 11 * MS && n <= 11 * MS + 2}, 32'h1);
    $display("test pause done");
  endtask : t_pause

  // start and braking peaks are larger but must be ignored
  task automatic t_torque;
    @(posedge clk);
    runActive <= 1'b1;
    startPhase <= 1'b1;
    torqueNow <= 16'h0300;
    repeat (3) @(posedge clk);
    startPhase <= 1'b0;
    torqueNow <= 16'h0120;
    repeat (3) @(posedge clk);
    torqueNow <= 16'h0090;
    brakePhase <= 1'b1;
    @(posedge clk);
    torqueNow <= 16'h0400;
    repeat (3) @(posedge clk);
    runActive <= 1'b0;
    brakePhase <= 1'b0;
    acc(1'b0, IDX_PEAK, 32'h0, 1'b0, 32'h0120);
    acc(1'b1, IDX_PEAK, 32'h5, 1'b1, 32'h0);
    u_dpd_sdo_master.idleGap = 3;
    acc(1'b1, IDX_HOLD, 32'h30, 1'b0, 32'h0);
    acc(1'b1, IDX_END_HOLD, 32'h77, 1'b0, 32'h0);
    @(posedge clk);
    standstill <= 1'b1;
    repeat (4) @(posedge clk);
    chk({16'h0, holdTorqueCmd}, 32'h30);
    chk({16'h0, endRunHoldTorque}, 32'h77);
    holdDemand <= 16'h0020;
    repeat (4) @(posedge clk);
    chk({16'h0, holdTorqueCmd}, 32'h20);
    $display("test torque done");
  endtask : t_torque

  task automatic tally_and_finish;
    $display("compares=%0d mismatches=%0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    t_defaults;
    t_ranges;
    t_readouts;
    t_status;
    t_pause;
    t_torque;
    tally_and_finish;
  end

  // watchdog well past the longest averaging wait
  initial
  begin
    #100000;
    nFail++;
    tally_and_finish;
  end
endmodule : dpd_param_dict_tb
